/* File: rtl/dead_band_timer.sv */
// counts dead-band ticks of the selected module clock
`timescale 1ns/100ps
module dead_band_timer (
   input wire logic sys_clk, // module clock
   input wire logic srst, // synchronous reset
   input wire logic start, // edge of the data input
   input wire logic tick, // one module clock period elapsed
   input wire logic [5:0] count, // programmed dead band
   output logic busy // dead band in progress
);
   logic [5:0] cnt_r;
   logic [5:0] cnt_nxt;
   logic busy_nxt;
   always_comb begin
      cnt_nxt = cnt_r;
      busy_nxt = busy;
      if (start) begin
         cnt_nxt = 6'h00;
         busy_nxt = (count != 6'h00);
      end else if (busy && tick) begin
         cnt_nxt = cnt_r + 6'h01;
         busy_nxt = ((cnt_r + 6'h01) < count);
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         cnt_r <= 6'h00;
         busy <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         busy <= busy_nxt;
      end
   end
endmodule

/* File: rtl/sync_two_ff.sv */
// two flip-flop synchroniser for a vector of levels
`timescale 1ns/100ps
module sync_two_ff #(
   parameter int W = 1
) (
   input wire logic sys_clk, // module clock
   input wire logic srst, // synchronous reset
   input wire logic [W-1:0] asyncIn, // level from another domain
   output logic [W-1:0] syncOut // synchronised level
);
   logic [W-1:0] stageOne_r;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stageOne_r <= '0;
         syncOut <= '0;
      end else begin
         stageOne_r <= asyncIn;
         syncOut <= stageOne_r;
      end
   end
endmodule

/* File: rtl/waveform_gen_shutdown_control.sv */
// auto-shutdown, restart and main control of the waveform generator
`timescale 1ns/100ps
`include "wgsd_cfg.svh"

// What this block does
// - software shutdown bit forces override levels
// - without auto-restart, shutdown holds while bit set
// - auto-restart clears bit, resumes on rising edge
// - enabled active-low sources override outputs after the two-stage synchroniser
// - sources: comparators one, two, cell two, pin
// - active enabled source holds shutdown state
// - two 2-bit fields set BD and AC levels
// - every shutdown event sets interrupt flag
// - no restart until shutdown cause gone
// - clear write ignored while condition present
// - auto-restart hardware clears bit when causes gone
// - keeps running in sleep on inputs
// - enable starts in shutdown state
// - load request loads buffers rise after fall
// - load request settable only when already enabled
// - 3-bit mode field selects output mode
// - dead band may fall short of count by one period
// - override levels ignore polarity inversion
// - clock selectable: system or 16 MHz oscillator
module waveform_gen_shutdown_control import wgsd_pkg::*; (
   input wire logic sys_clk, // 125 MHz clock
   input wire logic srst, // synchronous reset, active high
   input wire ahb_req_t ahbReq, // AHB-Lite address phase
   input wire logic hready, // bus ready
   input wire logic [31:0] hwdata, // write data
   output logic [31:0] hrdata, // read data
   output logic hreadyout, // slave ready
   output logic hresp, // always OKAY
   input wire logic [9:0] dataSources, // candidate data inputs, async
   input wire shutdown_src_t shutdownPinsN, // active-low sources, async
   input wire logic [3:0] polarityInvert, // per-output inversion
   input wire logic sleepMode, // device asleep
   output wave_out_t waveOut, // outputs A to D
   output logic waveformInterruptFlag, // shutdown event pulse
   output logic enabled // module enabled
);
   logic [7:0] mainCtl_r, mainCtl_nxt;
   logic [7:0] shdnCtl_r, shdnCtl_nxt;
   logic [3:0] srcEnable_r, srcEnable_nxt;
   logic [5:0] dbRise_r, dbRise_nxt, dbFall_r, dbFall_nxt;
   logic [5:0] dbRiseBuf_r, dbRiseBuf_nxt, dbFallBuf_r, dbFallBuf_nxt;
   logic clkSel_r, clkSel_nxt;
   logic [3:0] dataSel_r, dataSel_nxt;
   logic ldArmed_r, ldArmed_nxt;
   logic dataPrev_r, running_r, running_nxt;
   logic [15:0] phase_r, phase_nxt;
   logic tick_r;
   logic [16:0] phaseSum;
   logic wrPend_r, rdPend_r;
   logic [7:0] addr_r;
   logic [9:0] dataSync;
   shutdown_src_t srcSync;
   logic dataIn, dataRise, dataFall, hwCause, wrActive;
   logic riseBusy, fallBusy, irq_nxt;
   wave_out_t out_nxt;
   wave_mode_t mode;

   function automatic logic level_of(input logic [1:0] code,
                                     input logic inactiveLvl);
      case (override_level_t'(code))
         LVL_INACTIVE: level_of = inactiveLvl;
         LVL_ACTIVE: level_of = ~inactiveLvl;
         LVL_LOW: level_of = 1'b0;
         default: level_of = 1'b1;
      endcase
   endfunction

   sync_two_ff #(.W(10)) u_dataSync (
      .sys_clk(sys_clk),
      .srst(srst),
      .asyncIn(dataSources),
      .syncOut(dataSync)
   );
   sync_two_ff #(.W(4)) u_srcSync (
      .sys_clk(sys_clk),
      .srst(srst),
      .asyncIn(shutdownPinsN),
      .syncOut(srcSync)
   );

   assign mode = wave_mode_t'(mainCtl_r[2:0]);
   assign dataIn = dataSync[dataSel_r];
   assign dataRise = dataIn & ~dataPrev_r;
   assign dataFall = ~dataIn & dataPrev_r;
   assign hwCause = |(srcEnable_r & ~srcSync);
   assign wrActive = wrPend_r;
   assign phaseSum = {1'b0, phase_r} + {1'b0, `FAST_OSC_STEP};

   // the data input is sampled, so a dead band may run one tick short
   dead_band_timer u_riseTimer (
      .sys_clk(sys_clk),
      .srst(srst),
      .start(dataRise),
      .tick(tick_r),
      .count(dbRiseBuf_r),
      .busy(riseBusy)
   );
   dead_band_timer u_fallTimer (
      .sys_clk(sys_clk),
      .srst(srst),
      .start(dataFall),
      .tick(tick_r),
      .count(dbFallBuf_r),
      .busy(fallBusy)
   );

   // registers and shutdown state
   always_comb begin
      mainCtl_nxt = mainCtl_r;
      shdnCtl_nxt = shdnCtl_r;
      srcEnable_nxt = srcEnable_r;
      dbRise_nxt = dbRise_r;
      dbFall_nxt = dbFall_r;
      dbRiseBuf_nxt = dbRiseBuf_r;
      dbFallBuf_nxt = dbFallBuf_r;
      clkSel_nxt = clkSel_r;
      dataSel_nxt = dataSel_r;
      ldArmed_nxt = ldArmed_r;
      running_nxt = running_r;
      irq_nxt = 1'b0;
      if (wrActive) begin
         if (addr_r == `OFS_MAIN_CONTROL) begin
            mainCtl_nxt = {hwdata[7], 4'h0, hwdata[2:0]};
            mainCtl_nxt[`BIT_LD] = mainCtl_r[`BIT_LD]
               | (hwdata[`BIT_LD] & mainCtl_r[`BIT_EN]);
            if (hwdata[`BIT_EN] & ~mainCtl_r[`BIT_EN]) begin
               shdnCtl_nxt[`BIT_SHDN] = 1'b1;
               running_nxt = 1'b0;
               irq_nxt = 1'b1;
            end
         end else if (addr_r == `OFS_SHDN_CONTROL) begin
            shdnCtl_nxt = {shdnCtl_r[`BIT_SHDN], hwdata[6:2], 2'b00};
            if (hwdata[`BIT_SHDN]) begin
               shdnCtl_nxt[`BIT_SHDN] = 1'b1;
            end else if (!hwCause) begin
               shdnCtl_nxt[`BIT_SHDN] = 1'b0;
            end
         end else if (addr_r == `OFS_SRC_SELECT) begin
            srcEnable_nxt = hwdata[3:0];
         end else if (addr_r == `OFS_DB_RISE) begin
            dbRise_nxt = hwdata[5:0];
            if (!mainCtl_r[`BIT_EN]) dbRiseBuf_nxt = hwdata[5:0];
         end else if (addr_r == `OFS_DB_FALL) begin
            dbFall_nxt = hwdata[5:0];
            if (!mainCtl_r[`BIT_EN]) dbFallBuf_nxt = hwdata[5:0];
         end else if (addr_r == `OFS_CLK_SELECT) begin
            clkSel_nxt = hwdata[0];
         end else if (addr_r == `OFS_DATA_SELECT) begin
            dataSel_nxt = (hwdata[3:0] > 4'h9) ? 4'h0 : hwdata[3:0];
         end
      end
      if (!mainCtl_r[`BIT_EN]) begin
         ldArmed_nxt = 1'b0;
         mainCtl_nxt[`BIT_LD] = 1'b0;
      end else if (mainCtl_r[`BIT_LD]) begin
         if (dataFall) ldArmed_nxt = 1'b1;
         if (ldArmed_r && dataRise) begin
            dbRiseBuf_nxt = dbRise_r;
            dbFallBuf_nxt = dbFall_r;
            mainCtl_nxt[`BIT_LD] = 1'b0;
            ldArmed_nxt = 1'b0;
         end
      end
      if (hwCause && !shdnCtl_r[`BIT_SHDN]) begin
         shdnCtl_nxt[`BIT_SHDN] = 1'b1;
      end
      if (shdnCtl_nxt[`BIT_SHDN] && !shdnCtl_r[`BIT_SHDN]) begin
         irq_nxt = 1'b1;
      end
      if (shdnCtl_r[`BIT_SHDN] && shdnCtl_r[`BIT_REN] && !hwCause) begin
         shdnCtl_nxt[`BIT_SHDN] = wrActive && ((addr_r == `OFS_SHDN_CONTROL
            && hwdata[`BIT_SHDN]) || (addr_r == `OFS_MAIN_CONTROL
            && hwdata[`BIT_EN] && !mainCtl_r[`BIT_EN]));
      end
      if (shdnCtl_nxt[`BIT_SHDN]) begin
         running_nxt = 1'b0;
      end else if (!running_r && dataRise) begin
         running_nxt = 1'b1;
      end
   end

   // nothing here depends on the core clock stopping in sleep
   always_comb begin
      phase_nxt = clkSel_r ? phaseSum[15:0] : 16'h0000;
      out_nxt = '0;
      if (!mainCtl_r[`BIT_EN]) begin
         out_nxt = '0;
      end else if (!running_r) begin
         out_nxt.outA = level_of(shdnCtl_r[3:2], 1'b0);
         out_nxt.outC = level_of(shdnCtl_r[3:2], 1'b0);
         out_nxt.outB = level_of(shdnCtl_r[5:4], 1'b0);
         out_nxt.outD = level_of(shdnCtl_r[5:4], 1'b0);
      end else begin
         case (mode)
            MODE_ASYNC_STEER, MODE_SYNC_STEER: begin
               out_nxt.outA = dataIn;
               out_nxt.outB = dataIn;
               out_nxt.outC = dataIn;
               out_nxt.outD = dataIn;
            end
            MODE_FWD_BRIDGE: begin
               out_nxt.outA = 1'b1;
               out_nxt.outD = dataIn & ~fallBusy;
            end
            MODE_REV_BRIDGE: begin
               out_nxt.outC = 1'b1;
               out_nxt.outB = dataIn & ~riseBusy;
            end
            MODE_HALF_BRIDGE: begin
               out_nxt.outA = dataIn & ~riseBusy;
               out_nxt.outB = ~dataIn & ~fallBusy;
               out_nxt.outC = dataIn & ~riseBusy;
               out_nxt.outD = ~dataIn & ~fallBusy;
            end
            MODE_PUSH_PULL: begin
               out_nxt.outA = dataIn;
               out_nxt.outB = ~dataIn;
               out_nxt.outC = dataIn;
               out_nxt.outD = ~dataIn;
            end
            default: out_nxt = '0;
         endcase
         out_nxt = out_nxt ^ polarityInvert;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         mainCtl_r <= `RST_MAIN_CONTROL;
         shdnCtl_r <= `RST_SHDN_CONTROL;
         srcEnable_r <= 4'h0;
         dbRise_r <= `RST_DB;
         dbFall_r <= `RST_DB;
         dbRiseBuf_r <= `RST_DB;
         dbFallBuf_r <= `RST_DB;
         clkSel_r <= 1'b0;
         dataSel_r <= 4'h0;
         ldArmed_r <= 1'b0;
         running_r <= 1'b0;
         dataPrev_r <= 1'b0;
         phase_r <= 16'h0000;
         tick_r <= 1'b0;
         waveOut <= '0;
         waveformInterruptFlag <= 1'b0;
         enabled <= 1'b0;
      end else begin
         mainCtl_r <= mainCtl_nxt;
         shdnCtl_r <= shdnCtl_nxt;
         srcEnable_r <= srcEnable_nxt;
         dbRise_r <= dbRise_nxt;
         dbFall_r <= dbFall_nxt;
         dbRiseBuf_r <= dbRiseBuf_nxt;
         dbFallBuf_r <= dbFallBuf_nxt;
         clkSel_r <= clkSel_nxt;
         dataSel_r <= dataSel_nxt;
         ldArmed_r <= ldArmed_nxt;
         running_r <= running_nxt;
         dataPrev_r <= dataIn;
         phase_r <= phase_nxt;
         tick_r <= clkSel_r ? phaseSum[16] : 1'b1;
         waveOut <= out_nxt;
         waveformInterruptFlag <= irq_nxt;
         enabled <= mainCtl_nxt[`BIT_EN];
      end
   end

   // AHB-Lite slave, zero wait states
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         wrPend_r <= 1'b0;
         rdPend_r <= 1'b0;
         addr_r <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         if (hready) begin
            wrPend_r <= ahbReq.hsel & ahbReq.htrans[1] & ahbReq.hwrite;
            rdPend_r <= ahbReq.hsel & ahbReq.htrans[1] & ~ahbReq.hwrite;
            addr_r <= ahbReq.haddr[7:0];
         end
         hrdata <= 32'h0000_0000;
         if (hready && ahbReq.hsel && ahbReq.htrans[1]
             && !ahbReq.hwrite) begin
            if (ahbReq.haddr[7:0] == `OFS_MAIN_CONTROL) begin
               hrdata <= {24'h0, mainCtl_nxt};
            end else if (ahbReq.haddr[7:0] == `OFS_SHDN_CONTROL) begin
               hrdata <= {24'h0, shdnCtl_nxt};
            end else if (ahbReq.haddr[7:0] == `OFS_SRC_SELECT) begin
               hrdata <= {28'h0, srcEnable_nxt};
            end else if (ahbReq.haddr[7:0] == `OFS_DB_RISE) begin
               hrdata <= {26'h0, dbRise_nxt};
            end else if (ahbReq.haddr[7:0] == `OFS_DB_FALL) begin
               hrdata <= {26'h0, dbFall_nxt};
            end else if (ahbReq.haddr[7:0] == `OFS_CLK_SELECT) begin
               hrdata <= {31'h0, clkSel_nxt};
            end else if (ahbReq.haddr[7:0] == `OFS_DATA_SELECT) begin
               hrdata <= {28'h0, dataSel_nxt};
            end else if (ahbReq.haddr[7:0] == `OFS_STATUS) begin
               hrdata <= {26'h0, dataIn, running_nxt, ~srcSync};
            end
         end
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end
endmodule

/* File: rtl/wgsd_cfg.svh */
// register offsets, field positions, reset values and timing counts
`ifndef WGSD_CFG_SVH
`define WGSD_CFG_SVH
`define OFS_MAIN_CONTROL 8'h00
`define OFS_SHDN_CONTROL 8'h04
`define OFS_SRC_SELECT 8'h08
`define OFS_DB_RISE 8'h0C
`define OFS_DB_FALL 8'h10
`define OFS_CLK_SELECT 8'h14
`define OFS_DATA_SELECT 8'h18
`define OFS_STATUS 8'h1C
`define BIT_EN 7
`define BIT_LD 6
`define BIT_SHDN 7
`define BIT_REN 6
`define RST_MAIN_CONTROL 8'h00
`define RST_SHDN_CONTROL 8'h14
`define RST_SRC_SELECT 8'h00
`define RST_DB 6'h00
`define SYS_CLK_MHZ 125
`define FAST_OSC_MHZ 16
`define FAST_OSC_STEP 16'(`FAST_OSC_MHZ * 65536 / `SYS_CLK_MHZ)
`endif

/* File: rtl/wgsd_pkg.sv */
// types shared by the waveform shutdown control block
package wgsd_pkg;
   typedef enum logic [2:0] {
      MODE_ASYNC_STEER, MODE_SYNC_STEER, MODE_FWD_BRIDGE,
      MODE_REV_BRIDGE, MODE_HALF_BRIDGE, MODE_PUSH_PULL,
      MODE_RSVD6, MODE_RSVD7
   } wave_mode_t;
   typedef enum logic [1:0] {
      LVL_INACTIVE, LVL_ACTIVE, LVL_LOW, LVL_HIGH
   } override_level_t;
   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic hsel;
   } ahb_req_t;
   typedef struct packed {
      logic compOne;
      logic compTwo;
      logic cellTwo;
      logic pinSelect;
   } shutdown_src_t;
   typedef struct packed {
      logic outA;
      logic outB;
      logic outC;
      logic outD;
   } wave_out_t;
endpackage

/* File: sim/bridge_model.sv */
// far-side model: current comparators of the bridge tripping the block
`timescale 1ns/100ps
module bridge_model import wgsd_pkg::*; (
   input wire logic [3:0] tripCmd, // overcurrent per source, high = trip
   output shutdown_src_t shutdownPinsN // active-low trip lines
);
   initial shutdownPinsN = 4'hF;
   // trip lines move a few ns off the clock, as a real comparator would
   always @(tripCmd) begin
      shutdownPinsN <= #3 ~tripCmd;
   end
endmodule

/* File: sim/tb.sv */
// bench for the waveform shutdown control block
`timescale 1ns/100ps
`include "wgsd_cfg.svh"
module tb import wgsd_pkg::*; ;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   ahb_req_t ahbReq;
   logic [31:0] hwdata, hrdata;
   logic hreadyout, hresp, irq, enabled, sleepMode;
   logic [9:0] dataSources;
   logic [3:0] polarityInvert, trip;
   shutdown_src_t pinsN;
   wave_out_t waveOut;
   int errTotal = 0;
   int nCompared = 0;
   int irqCnt = 0;
   waveform_gen_shutdown_control dut (.sys_clk(sys_clk), .srst(srst),
      .ahbReq(ahbReq), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .dataSources(dataSources), .shutdownPinsN(pinsN),
      .polarityInvert(polarityInvert), .sleepMode(sleepMode),
      .waveOut(waveOut), .waveformInterruptFlag(irq), .enabled(enabled));
   bridge_model far (.tripCmd(trip), .shutdownPinsN(pinsN));
   initial begin
      forever #4 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (irq === 1'b1) irqCnt <= irqCnt + 1;
   end
   task automatic stopTest;
      $display("compared %0d mismatches %0d", nCompared, errTotal);
      if (errTotal == 0 && nCompared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      nCompared++;
      if (g !== e) begin
         errTotal++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic waitRdy;
      for (int i = 0; i < 50; i++) begin
         @(posedge sys_clk);
         if (hreadyout === 1'b1) return;
      end
      errTotal++;
      stopTest();
   endtask
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      ahbReq <= '{{24'h0, a}, 2'b10, w, 3'b010, 1'b1};
      waitRdy();
      ahbReq.htrans <= 2'b00;
      hwdata <= d;
      waitRdy();
      q = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask
   task automatic rdc(string nm, logic [7:0] a, logic [31:0] m, e);
      logic [31:0] q;
      xfer(1'b0, a, 32'h0, q);
      chk(nm, e, q & m);
   endtask
   task automatic pollc(string nm, logic [7:0] a, logic [31:0] m, e);
      logic [31:0] q;
      for (int i = 0; i < 40; i++) begin
         xfer(1'b0, a, 32'h0, q);
         if ((q & m) === e) break;
      end
      chk(nm, e, q & m);
   endtask
   // data input edge, then time for the synchroniser
   task automatic dat(input logic v);
      dataSources[0] <= v;
      repeat (5) @(posedge sys_clk);
   endtask
   initial begin
      ahbReq = '0;
      hwdata = 32'h0;
      dataSources = 10'h000;
      polarityInvert = 4'hF;
      sleepMode = 1'b0;
      trip = 4'h0;
      repeat (5) @(posedge sys_clk);
      srst <= 1'b0;
      @(posedge sys_clk);
      rdc("main", `OFS_MAIN_CONTROL, 32'hFFFFFFFF, 32'h0);
      rdc("shdn", `OFS_SHDN_CONTROL, 32'hFFFFFFFF, 32'h14);
      rdc("src", `OFS_SRC_SELECT, 32'hFFFFFFFF, 32'h0);
      rdc("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0);
      for (int m = 0; m < 6; m++) begin
         wr(`OFS_MAIN_CONTROL, 32'(m));
         rdc("mode", `OFS_MAIN_CONTROL, 32'h7, 32'(m));
      end
      wr(`OFS_SHDN_CONTROL, 32'h38);
      wr(`OFS_DATA_SELECT, 32'h0);
      wr(`OFS_MAIN_CONTROL, 32'hC4);
      rdc("en and ld", `OFS_MAIN_CONTROL, 32'hC0, 32'h80);
      chk("enabled", 32'h1, 32'(enabled));
      rdc("start", `OFS_SHDN_CONTROL, 32'h80, 32'h80);
      chk("start level", 32'h5, 32'(waveOut));
      chk("irq enable", 32'h1, 32'(irqCnt));
      repeat (20) @(posedge sys_clk);
      rdc("held", `OFS_SHDN_CONTROL, 32'h80, 32'h80);
      wr(`OFS_SHDN_CONTROL, 32'h38);
      rdc("before rise", `OFS_STATUS, 32'h10, 32'h0);
      dat(1'b1);
      rdc("running", `OFS_STATUS, 32'h10, 32'h10);
      wr(`OFS_MAIN_CONTROL, 32'hC4);
      rdc("ld set", `OFS_MAIN_CONTROL, 32'h40, 32'h40);
      dat(1'b0);
      rdc("ld after fall", `OFS_MAIN_CONTROL, 32'h40, 32'h40);
      dat(1'b1);
      rdc("ld after rise", `OFS_MAIN_CONTROL, 32'h40, 32'h0);
      wr(`OFS_CLK_SELECT, 32'h1);
      rdc("clock sel", `OFS_CLK_SELECT, 32'hFF, 32'h1);
      sleepMode <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         wr(`OFS_SRC_SELECT, 32'(1 << s));
         trip <= 4'(1 << s);
         pollc("trip", `OFS_SHDN_CONTROL, 32'h80, 32'h80);
         // let the counter take a pulse seen at this very edge
         @(posedge sys_clk);
         chk("irq trip", 32'(s + 2), 32'(irqCnt));
         wr(`OFS_SHDN_CONTROL, 32'h38);
         rdc("clear refused", `OFS_SHDN_CONTROL, 32'h80, 32'h80);
         chk("trip level", 32'h5, 32'(waveOut));
         trip <= 4'h0;
         repeat (5) @(posedge sys_clk);
         wr(`OFS_SHDN_CONTROL, 32'h38);
         rdc("cleared", `OFS_SHDN_CONTROL, 32'h80, 32'h0);
      end
      wr(`OFS_SRC_SELECT, 32'h8);
      trip <= 4'h8;
      pollc("trip again", `OFS_SHDN_CONTROL, 32'h80, 32'h80);
      for (int c = 0; c < 4; c++) begin
         wr(`OFS_SHDN_CONTROL, 32'(c * 20));
         repeat (4) @(posedge sys_clk);
         chk("level code", (c % 2) ? 32'hF : 32'h0, 32'(waveOut));
      end
      wr(`OFS_SRC_SELECT, 32'h0);
      wr(`OFS_SHDN_CONTROL, 32'h38);
      rdc("source off", `OFS_SHDN_CONTROL, 32'h80, 32'h0);
      trip <= 4'h0;
      sleepMode <= 1'b0;
      wr(`OFS_SHDN_CONTROL, 32'hB8);
      rdc("sw shutdown", `OFS_SHDN_CONTROL, 32'h80, 32'h80);
      chk("sw level", 32'h5, 32'(waveOut));
      chk("irq sw", 32'h7, 32'(irqCnt));
      wr(`OFS_SHDN_CONTROL, 32'hF8);
      pollc("auto clear", `OFS_SHDN_CONTROL, 32'h80, 32'h0);
      wr(`OFS_SRC_SELECT, 32'h1);
      trip <= 4'h1;
      pollc("auto trip", `OFS_SHDN_CONTROL, 32'h80, 32'h80);
      repeat (10) @(posedge sys_clk);
      rdc("auto held", `OFS_SHDN_CONTROL, 32'h80, 32'h80);
      trip <= 4'h0;
      pollc("auto release", `OFS_SHDN_CONTROL, 32'h80, 32'h0);
      dat(1'b0);
      dat(1'b1);
      rdc("auto running", `OFS_STATUS, 32'h10, 32'h10);
      stopTest();
   end
endmodule
bind waveform_gen_shutdown_control wgsd_asserts chk_u (.sys_clk(sys_clk),
   .srst(srst), .ahbReq(ahbReq), .hready(hready), .hwdata(hwdata),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .dataSources(dataSources), .shutdownPinsN(shutdownPinsN),
   .polarityInvert(polarityInvert), .sleepMode(sleepMode),
   .waveOut(waveOut), .waveformInterruptFlag(waveformInterruptFlag),
   .enabled(enabled));

/* File: sim/wgsd_asserts.sv */
// port checks of the waveform shutdown control block
`timescale 1ns/100ps
`include "wgsd_cfg.svh"
module wgsd_asserts import wgsd_pkg::*; (
   input wire logic sys_clk, // clock
   input wire logic srst, // reset
   input wire ahb_req_t ahbReq, // address phase
   input wire logic hready, // bus ready
   input wire logic [31:0] hwdata, // write data
   input wire logic [31:0] hrdata, // read data
   input wire logic hreadyout, // slave ready
   input wire logic hresp, // response
   input wire logic [9:0] dataSources, // data inputs
   input wire shutdown_src_t shutdownPinsN, // trip lines
   input wire logic [3:0] polarityInvert, // inversion
   input wire logic sleepMode, // asleep
   input wire wave_out_t waveOut, // outputs
   input wire logic waveformInterruptFlag, // event pulse
   input wire logic enabled // enable copy
);
   logic ph_r, ph_nxt, wr_r, wr_nxt, en_r, en_nxt;
   logic [7:0] ad_r, ad_nxt, ctl_r, ctl_nxt, src_r, src_nxt;
   logic [2:0] md_r, md_nxt;
   logic wrNow, rdNow;
   assign wrNow = ph_r && wr_r;
   assign rdNow = ph_r && !wr_r;
   always_comb begin
      ph_nxt = hready && ahbReq.hsel && ahbReq.htrans[1];
      wr_nxt = ahbReq.hwrite;
      ad_nxt = ahbReq.haddr[7:0];
      en_nxt = en_r;
      md_nxt = md_r;
      ctl_nxt = ctl_r;
      src_nxt = src_r;
      if (wrNow && ad_r == `OFS_MAIN_CONTROL) begin
         en_nxt = hwdata[7];
         md_nxt = hwdata[2:0];
      end
      if (wrNow && ad_r == `OFS_SHDN_CONTROL) begin
         ctl_nxt = hwdata[7:0];
      end
      if (wrNow && ad_r == `OFS_SRC_SELECT) begin
         src_nxt = hwdata[7:0];
      end
   end
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         ph_r <= 1'b0;
         wr_r <= 1'b0;
         ad_r <= 8'h00;
         en_r <= 1'b0;
         md_r <= 3'h0;
         ctl_r <= `RST_SHDN_CONTROL;
         src_r <= `RST_SRC_SELECT;
      end else begin
         ph_r <= ph_nxt;
         wr_r <= wr_nxt;
         ad_r <= ad_nxt;
         en_r <= en_nxt;
         md_r <= md_nxt;
         ctl_r <= ctl_nxt;
         src_r <= src_nxt;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (srst);
   ready_high_a: assert property (hreadyout)
      else $error("hreadyout dropped");
   resp_okay_a: assert property (!hresp)
      else $error("hresp not okay");
   rdata_idle_a: assert property (!rdNow |-> hrdata == 32'h0)
      else $error("hrdata outside read phase");
   upper_zero_a: assert property (hrdata[31:8] == 24'h0)
      else $error("hrdata upper bits set");
   main_rb_a: assert property (
      rdNow && ad_r == `OFS_MAIN_CONTROL |->
      hrdata[7] == en_r && hrdata[2:0] == md_r)
      else $error("main control readback");
   level_rb_a: assert property (
      rdNow && ad_r == `OFS_SHDN_CONTROL |->
      hrdata[5:2] == ctl_r[5:2])
      else $error("override field readback");
   enable_out_a: assert property (
      $stable(en_r) |-> enabled == en_r)
      else $error("enabled not following bit");
   irq_pulse_a: assert property (
      waveformInterruptFlag |=> !waveformInterruptFlag)
      else $error("interrupt flag longer than a cycle");
   trip_override_a: assert property (
      (enabled && $stable(ctl_r) &&
      (src_r[3:0] & ~4'(shutdownPinsN)) != 4'h0) [*6] |->
      waveOut == {ctl_r[2], ctl_r[4], ctl_r[2], ctl_r[4]})
      else $error("outputs not at override levels");
endmodule
